// ---- cid_decode.sv ----
// instruction format decoder with execution cycle sequencing
`timescale 1ns/1ps
`default_nettype none

module cid_decode
	import cid_pkg::*;
(
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic [WORD_W-1:0]    instr_i,        // word from program memory
	input  wire logic                 cond_true_i,    // condition result for skips and branches
	input  wire logic                 ext_en_i,       // extended group enabled
	input  wire logic [3:0]           bank_sel_i,     // bank_selector value
	output logic [PH_W-1:0]           phase_o,
	output logic                      cyc_end_o,
	output logic                      start_o,        // pulse: new instruction accepted
	output logic [1:0]                cat_o,
	output logic [7:0]                file_addr_o,
	output logic                      dest_acc_o,     // result to working_accumulator
	output logic                      dest_file_o,    // result to file register
	output logic                      banked_o,       // bank_selector supplies bank
	output logic [11:0]               data_addr_o,
	output logic [2:0]                bit_sel_o,
	output logic [7:0]                bit_mask_o,
	output logic [7:0]                literal_o,
	output logic [1:0]                ptr_sel_o,      // indirect_pointer choice
	output logic [19:0]               prog_addr_o,
	output logic                      fast_o,         // shadow registers in use
	output logic [1:0]                tbl_mode_o,     // table_pointer update mode
	output logic                      ext_op_o,
	output logic [EXT_IDX_W-1:0]      ext_idx_o,
	output logic                      exec_nop_o,     // current cycle executes as nop
	output logic                      dw_o,           // double-word instruction in flight
	output logic [1:0]                cycles_o        // cycles of current instruction
);

	//------------------------------------------------------------------------------
	// phase divider
	//------------------------------------------------------------------------------
	logic cyc_end;                                        // last clock of the cycle

	cid_phase u_phase (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.phase_o    (phase_o),
		.cyc_end_o  (cyc_end)
	);

	//------------------------------------------------------------------------------
	// decoding helpers
	//------------------------------------------------------------------------------
	// group nibble to category; second words fall to control
	function automatic cid_cat_t cat_of(input logic [WORD_W-1:0] w);
		logic [3:0] g;
		g = w[GRP_HI:GRP_LO];
		if (g >= G_BYTE_L && g <= G_BYTE_H) begin
			cat_of = CAT_BYTE;
		end else if (g >= G_BIT_L && g <= G_BIT_H) begin
			cat_of = CAT_BIT;
		end else if (g == G_LIT || g == G_LITPTR) begin
			cat_of = CAT_LIT;
		end else begin
			cat_of = CAT_CTRL;
		end
	endfunction

	// single-word instruction needs an extra cycle
	function automatic logic extra_of(input logic [WORD_W-1:0] w, input logic c);
		logic [3:0] g;
		g = w[GRP_HI:GRP_LO];
		extra_of = (g >= G_SKIP_L && g <= G_BIT_H && c)
		         || (g == G_BRA && (!w[BR_COND] || c))
		         || (g == G_CTRL && w[SUB_HI:SUB_LO] == C_RET);
	endfunction

	//------------------------------------------------------------------------------
	// state
	//------------------------------------------------------------------------------
	typedef struct packed {
		cid_st_t              st;
		logic                 pend;       // taken long branch owes a flush cycle
		logic                 start;
		cid_cat_t             cat;
		logic [7:0]           file_addr;
		logic                 dest_acc;
		logic                 dest_file;
		logic                 banked;
		logic [11:0]          data_addr;
		logic [2:0]           bit_sel;
		logic [7:0]           bit_mask;
		logic [7:0]           literal;
		logic [1:0]           ptr_sel;
		logic [19:0]          prog_addr;
		logic                 fast;
		cid_tbl_t             tbl_mode;
		logic                 ext_op;
		logic [EXT_IDX_W-1:0] ext_idx;
		logic                 exec_nop;
		logic                 dw;
		logic [1:0]           dw_kind;
		logic [1:0]           cycles;
		logic                 cyc_end;
	} cid_dec_t;

	// enum members named explicitly: a bare '0 is not assignment compatible with an enum
	localparam cid_dec_t RESET_S = '{st: ST_FETCH, cat: CAT_BYTE, tbl_mode: TBL_SAME, cycles: CYC_ONE, default: '0};

	cid_dec_t s;
	cid_dec_t next_s;
	logic [3:0] grp;                                      // group nibble of incoming word
	logic [3:0] sub;                                      // control sub-opcode

	assign grp = instr_i[GRP_HI:GRP_LO];
	assign sub = instr_i[SUB_HI:SUB_LO];

	// sequencing and field extraction, once per instruction cycle
	always_comb begin
		next_s         = s;
		next_s.start   = 1'b0;
		next_s.cyc_end = cyc_end;
		if (cyc_end) begin
			case (s.st)
				ST_FETCH: begin
					// fresh instruction; fields cleared where the format lacks them
					next_s          = RESET_S;
					next_s.cyc_end  = cyc_end;
					next_s.start    = 1'b1;
					next_s.cat      = cat_of(instr_i);
					next_s.cycles   = extra_of(instr_i, cond_true_i) ? CYC_TWO : CYC_ONE;
					next_s.st       = extra_of(instr_i, cond_true_i) ? ST_FLUSH : ST_FETCH;
					case (next_s.cat)
						CAT_BYTE: begin
							next_s.file_addr = instr_i[7:0];
							next_s.dest_file = instr_i[DEST_BIT];
							next_s.dest_acc  = !instr_i[DEST_BIT];
							next_s.banked    = instr_i[ACC_BIT];
						end
						CAT_BIT: begin
							next_s.file_addr = instr_i[7:0];
							next_s.bit_sel   = instr_i[BIT_HI:BIT_LO];
							next_s.bit_mask  = 8'h01 << instr_i[BIT_HI:BIT_LO];
							next_s.banked    = instr_i[ACC_BIT];
						end
						CAT_LIT: begin
							next_s.literal = instr_i[7:0];
							if (grp == G_LITPTR) begin
								next_s.ptr_sel = instr_i[PTR_HI:PTR_LO];
							end
						end
						default: begin
							if (grp == G_SECOND) begin
								next_s.exec_nop = 1'b1;
							end else if (grp == G_BRA) begin
								// relative offset, sign extended
								next_s.prog_addr = {{9{instr_i[10]}}, instr_i[10:0]};
							end else if (grp == G_DW) begin
								next_s.dw      = 1'b1;
								next_s.dw_kind = instr_i[DW_KHI:DW_KLO];
								next_s.cycles  = CYC_TWO;
								next_s.st      = ST_SECOND;
								next_s.prog_addr[19:12] = instr_i[7:0];
								if (instr_i[DW_KHI:DW_KLO] == DW_CALL) begin
									next_s.fast = instr_i[DW_FAST];
								end
								if (instr_i[DW_KHI:DW_KLO] == DW_LDPTR) begin
									next_s.cat     = CAT_LIT;
									next_s.ptr_sel = instr_i[DW_PHI:DW_PLO];
								end
								if (instr_i[DW_KHI:DW_KLO] == DW_LBRA && cond_true_i) begin
									next_s.pend   = 1'b1;
									next_s.cycles = CYC_THREE;
								end
							end else if (sub == C_RET) begin
								next_s.fast = instr_i[0];
							end else if (sub == C_TBLRD || sub == C_TBLWR) begin
								next_s.tbl_mode = cid_tbl_t'(instr_i[1:0]);
							end else if (sub == C_EXT && ext_en_i) begin
								next_s.ext_op  = 1'b1;
								next_s.ext_idx = instr_i[EXT_IDX_W-1:0];
							end else begin
								next_s.exec_nop = 1'b1;                // no-operand or disabled op
							end
						end
					endcase
					// access selector picks fixed region or bank
					next_s.data_addr = {next_s.banked ? bank_sel_i : ACCESS_BANK, instr_i[7:0]};
				end
				ST_SECOND: begin
					// second word completes the wide operand
					if (s.dw_kind == DW_LDPTR) begin
						next_s.literal = instr_i[7:0];
					end else begin
						next_s.prog_addr[11:0] = instr_i[11:0];
					end
					next_s.st = s.pend ? ST_FLUSH : ST_FETCH;
				end
				ST_FLUSH: begin
					next_s.exec_nop = 1'b1;
					next_s.pend     = 1'b0;
					next_s.st       = ST_FETCH;
				end
				default: begin
					next_s = RESET_S;                              // illegal code recovers
				end
			endcase
		end
	end

	// register state
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s <= RESET_S;
		end else begin
			s <= next_s;
		end
	end

	//------------------------------------------------------------------------------
	// outputs, all taken from state flops
	//------------------------------------------------------------------------------
	assign cyc_end_o   = s.cyc_end;
	assign start_o     = s.start;
	assign cat_o       = s.cat;
	assign file_addr_o = s.file_addr;
	assign dest_acc_o  = s.dest_acc;
	assign dest_file_o = s.dest_file;
	assign banked_o    = s.banked;
	assign data_addr_o = s.data_addr;
	assign bit_sel_o   = s.bit_sel;
	assign bit_mask_o  = s.bit_mask;
	assign literal_o   = s.literal;
	assign ptr_sel_o   = s.ptr_sel;
	assign prog_addr_o = s.prog_addr;
	assign fast_o      = s.fast;
	assign tbl_mode_o  = s.tbl_mode;
	assign ext_op_o    = s.ext_op;
	assign ext_idx_o   = s.ext_idx;
	assign exec_nop_o  = s.exec_nop;
	assign dw_o        = s.dw;
	assign cycles_o    = s.cycles;

	//------------------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------------------
	// helper: word accepted in fetch
	logic take;
	assign take = cyc_end && s.st == ST_FETCH;

	single_cycle_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		take && grp != G_DW && !extra_of(instr_i, cond_true_i) |=> s.st == ST_FETCH && s.cycles == CYC_ONE)
		else $error("plain single word not one cycle");
	taken_two_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		take && grp != G_DW && extra_of(instr_i, cond_true_i) |=> s.st == ST_FLUSH ##4 s.exec_nop)
		else $error("taken single word lacks nop cycle");
	double_word_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		take && grp == G_DW && !cond_true_i |=> s.st == ST_SECOND ##4 s.st == ST_FETCH)
		else $error("double word not two cycles");
	long_branch_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		take && grp == G_DW && instr_i[DW_KHI:DW_KLO] == DW_LBRA && cond_true_i
		|=> s.cycles == CYC_THREE ##4 s.st == ST_FLUSH ##4 s.st == ST_FETCH)
		else $error("taken long branch not three cycles");
	lone_second_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		take && grp == G_SECOND |=> s.exec_nop && s.cycles == CYC_ONE && !s.dw)
		else $error("lone second word not a nop");
	dest_sel_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		take && cat_of(instr_i) == CAT_BYTE |=> s.dest_file == $past(instr_i[DEST_BIT]) && s.dest_acc != s.dest_file)
		else $error("destination selector mismatch");
	bit_mask_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s.start && s.cat == CAT_BIT |-> s.bit_mask == (8'h01 << s.bit_sel) && $onehot(s.bit_mask))
		else $error("bit mask does not match bit number");
	bank_sel_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		take && cat_of(instr_i) inside {CAT_BYTE, CAT_BIT}
		|=> s.data_addr[11:8] == (s.banked ? $past(bank_sel_i) : ACCESS_BANK))
		else $error("bank select wrong");
	fast_ctrl_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s.fast |-> s.cat == CAT_CTRL)
		else $error("fast mode outside control op");
	ext_gate_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		take && !ext_en_i |=> !s.ext_op)
		else $error("extended op decoded while disabled");

	dw_cv : cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s.start && s.dw ##4 s.st == ST_SECOND);
	flush_cv : cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s.start && s.cycles == CYC_THREE);
	tbl_cv : cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		s.start && s.tbl_mode == TBL_PREINC);

endmodule

`default_nettype wire

// ---- cid_phase.sv ----
// instruction cycle phase divider: four clock periods per instruction cycle
`timescale 1ns/1ps
`default_nettype none

module cid_phase
	import cid_pkg::*;
(
	input  wire logic            core_clk_i,
	input  wire logic            rst_n_i,
	output logic [PH_W-1:0]      phase_o,
	output logic                 cyc_end_o
);

	//------------------------------------------------------------------------------
	// state
	//------------------------------------------------------------------------------
	typedef struct packed {
		logic [PH_W-1:0] ph;     // current phase
		logic            last;   // high in the last phase only
	} cid_ph_t;

	cid_ph_t s;
	cid_ph_t next_s;

	// advance phase; the end pulse is precomputed so it leaves a flop
	always_comb begin
		next_s      = s;
		next_s.ph   = s.ph + 1'b1;
		next_s.last = (next_s.ph == PH_LAST);
	end

	// register state
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign phase_o   = s.ph;
	assign cyc_end_o = s.last;

	//------------------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------------------
	cycle_four_a : assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cyc_end_o |=> !cyc_end_o [*3] ##1 cyc_end_o)
		else $error("instruction cycle is not four clocks");

	cyc_end_cv : cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cyc_end_o ##4 cyc_end_o);

endmodule

`default_nettype wire

// ---- cid_pkg.sv ----
// package of encodings, field positions and timing counts for the instruction decoder
//------------------------------------------------------------------------------
// Functional notes
// - 75 base plus 8 extended instructions
// - one 16-bit word; four take two
// - single word splits into opcode and operands
// - four categories: byte, bit, literal, control
// - byte ops carry file, destination, access fields
// - destination zero: accumulator; one: file register
// - bit ops carry file, bit number, access
// - literal ops: constant, pointer choice, or none
// - control ops: address, fast mode, table mode
// - lone second word (top nibble ones) is nop
// - one cycle; two if taken or jumping
// - double-word instructions take two cycles
// - instruction cycle is four clock periods
// - taken two-word branch takes three cycles
// - access zero: fixed region; one: bank selector
// - bit number is three bits, 0 to 7
// - fast mode one uses shadows, zero not
// - table modes: same, post-inc, post-dec, pre-inc
//------------------------------------------------------------------------------
package cid_pkg;

	//------------------------------------------------------------------------------
	// sizes and counts
	//------------------------------------------------------------------------------
	localparam int          WORD_W           = 16;       // program memory word
	localparam int          BASE_INSTR_COUNT = 75;       // standard group size
	localparam int          EXT_INSTR_COUNT  = 8;        // extended group size
	localparam int          EXT_IDX_W        = $clog2(EXT_INSTR_COUNT);
	localparam int          PHASES_PER_CYC   = 4;        // clock periods per instruction cycle
	localparam int          PH_W             = $clog2(PHASES_PER_CYC);
	localparam logic [1:0]  PH_LAST          = 2'(PHASES_PER_CYC - 1);
	localparam logic [1:0]  CYC_ONE          = 2'h1;
	localparam logic [1:0]  CYC_TWO          = 2'h2;
	localparam logic [1:0]  CYC_THREE        = 2'h3;

	//------------------------------------------------------------------------------
	// field positions within a word
	//------------------------------------------------------------------------------
	localparam int          GRP_HI   = 15;               // group nibble
	localparam int          GRP_LO   = 12;
	localparam int          DEST_BIT = 9;                // byte ops: destination
	localparam int          ACC_BIT  = 8;                // byte and bit ops: access selector
	localparam int          BIT_HI   = 11;               // bit ops: bit number
	localparam int          BIT_LO   = 9;
	localparam int          SUB_HI   = 11;               // control: sub-opcode
	localparam int          SUB_LO   = 8;
	localparam int          PTR_HI   = 9;                // short pointer load field
	localparam int          PTR_LO   = 8;
	localparam int          DW_KHI   = 9;                // double-word kind
	localparam int          DW_KLO   = 8;
	localparam int          DW_FAST  = 7;                // double-word call fast bit
	localparam int          DW_PHI   = 5;                // double-word pointer field
	localparam int          DW_PLO   = 4;
	localparam int          BR_COND  = 11;               // relative branch is conditional
	localparam logic [3:0]  ACCESS_BANK = 4'h0;          // bank used when access selector is 0

	//------------------------------------------------------------------------------
	// group nibble codes
	//------------------------------------------------------------------------------
	localparam logic [3:0]  G_CTRL   = 4'h0;
	localparam logic [3:0]  G_BYTE_L = 4'h1;
	localparam logic [3:0]  G_BYTE_H = 4'h5;
	localparam logic [3:0]  G_BIT_L  = 4'h6;
	localparam logic [3:0]  G_SKIP_L = 4'h9;             // bit tests that skip when true
	localparam logic [3:0]  G_BIT_H  = 4'ha;
	localparam logic [3:0]  G_LIT    = 4'hb;
	localparam logic [3:0]  G_LITPTR = 4'hc;
	localparam logic [3:0]  G_BRA    = 4'hd;
	localparam logic [3:0]  G_DW     = 4'he;
	localparam logic [3:0]  G_SECOND = 4'hf;             // tag of every second word

	// control sub-opcodes
	localparam logic [3:0]  C_NOP    = 4'h0;
	localparam logic [3:0]  C_RET    = 4'h1;
	localparam logic [3:0]  C_TBLRD  = 4'h2;
	localparam logic [3:0]  C_TBLWR  = 4'h3;
	localparam logic [3:0]  C_EXT    = 4'h8;

	// double-word kinds
	localparam logic [1:0]  DW_GOTO  = 2'h0;
	localparam logic [1:0]  DW_CALL  = 2'h1;
	localparam logic [1:0]  DW_LDPTR = 2'h2;
	localparam logic [1:0]  DW_LBRA  = 2'h3;             // long conditional branch

	//------------------------------------------------------------------------------
	// types
	//------------------------------------------------------------------------------
	typedef enum logic [1:0] {
		CAT_BYTE = 2'h0,
		CAT_BIT  = 2'h1,
		CAT_LIT  = 2'h2,
		CAT_CTRL = 2'h3
	} cid_cat_t;

	typedef enum logic [1:0] {
		TBL_SAME    = 2'h0,
		TBL_POSTINC = 2'h1,
		TBL_POSTDEC = 2'h2,
		TBL_PREINC  = 2'h3
	} cid_tbl_t;

	typedef enum logic [2:0] {
		ST_FETCH  = 3'h1,
		ST_SECOND = 3'h2,
		ST_FLUSH  = 3'h4
	} cid_st_t;

endpackage

// ---- tb_core_instruction_decode_timing.sv ----
// self-checking testbench for the instruction decoder and its cycle timing
`timescale 1ns/1ps
`default_nettype none

module tb_core_instruction_decode_timing import cid_pkg::*;;
	//------------------------------------------------------------------------------
	// stimulus and observed signals
	//------------------------------------------------------------------------------
	logic                 core_clk_i;    // core clock
	logic                 rst_n_i;       // synchronous reset, active low
	logic [WORD_W-1:0]    instr_i;       // program memory word
	logic                 cond_true_i;   // condition result
	logic                 ext_en_i;      // extended group enable
	logic [3:0]           bank_sel_i;    // bank_selector value
	logic [PH_W-1:0]      phase_o;
	logic                 cyc_end_o;
	logic                 start_o;
	logic [1:0]           cat_o;
	logic [7:0]           file_addr_o;
	logic                 dest_acc_o;
	logic                 dest_file_o;
	logic                 banked_o;
	logic [11:0]          data_addr_o;
	logic [2:0]           bit_sel_o;
	logic [7:0]           bit_mask_o;
	logic [7:0]           literal_o;
	logic [1:0]           ptr_sel_o;
	logic [19:0]          prog_addr_o;
	logic                 fast_o;
	logic [1:0]           tbl_mode_o;
	logic                 ext_op_o;
	logic [EXT_IDX_W-1:0] ext_idx_o;
	logic                 exec_nop_o;
	logic                 dw_o;
	logic [1:0]           cycles_o;
	int                   miscompares;   // mismatches seen
	int                   total_checks;  // comparisons made

	cid_decode i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i), .cond_true_i(cond_true_i),
		.ext_en_i(ext_en_i), .bank_sel_i(bank_sel_i), .phase_o(phase_o), .cyc_end_o(cyc_end_o), .start_o(start_o),
		.cat_o(cat_o), .file_addr_o(file_addr_o), .dest_acc_o(dest_acc_o), .dest_file_o(dest_file_o),
		.banked_o(banked_o), .data_addr_o(data_addr_o), .bit_sel_o(bit_sel_o), .bit_mask_o(bit_mask_o),
		.literal_o(literal_o), .ptr_sel_o(ptr_sel_o), .prog_addr_o(prog_addr_o), .fast_o(fast_o),
		.tbl_mode_o(tbl_mode_o), .ext_op_o(ext_op_o), .ext_idx_o(ext_idx_o), .exec_nop_o(exec_nop_o),
		.dw_o(dw_o), .cycles_o(cycles_o));

	//------------------------------------------------------------------------------
	// clock, comparison and closing report
	//------------------------------------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	// case equality so an unknown never passes for a match
	task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// one word per instruction cycle: set up while phase is 3, look at the answer in phase 0
	task automatic put(input logic [15:0] w, input logic c = 1'b0, input logic e = 1'b0, input logic [3:0] b = 4'h0);
		int n;
		n = 0;
		@(negedge core_clk_i);
		while (phase_o !== 2'h2) begin
			n++;
			if (n > 8) begin
				miscompares++;
				summarize();
			end
			@(negedge core_clk_i);
		end
		@(posedge core_clk_i);
		instr_i     <= w;
		cond_true_i <= c;
		ext_en_i    <= e;
		bank_sel_i  <= b;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk("cyc_end", cyc_end_o, 20'h1);
		chk("phase", 20'(phase_o), 20'h0);
	endtask

	// the extra cycle of a taken or jumping instruction ignores the word offered
	task automatic flush();
		put(16'h13ab);
		chk("flush start", start_o, 20'h0);
		chk("flush nop", exec_nop_o, 20'h1);
	endtask

	//------------------------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------------------------
	task automatic t_phase();
		int pulses;
		pulses = 0;
		// skip the first cycle after reset, in which cyc_end_o stays low; its end pulse shows in the next phase 0 and is counted
		repeat (4) @(negedge core_clk_i);
		for (int i = 0; i < 16; i++) begin
			@(negedge core_clk_i);
			if (cyc_end_o === 1'b1) begin
				pulses++;
			end
		end
		chk("cyc_end count", 20'(pulses), 20'h4);
	endtask

	task automatic t_byte();
		put(16'h13ab, 1'b0, 1'b0, 4'h7);
		chk("start", start_o, 20'h1);
		chk("cat byte", cat_o, 20'(CAT_BYTE));
		chk("file", file_addr_o, 20'hab);
		chk("dest file", dest_file_o, 20'h1);
		chk("dest acc", dest_acc_o, 20'h0);
		chk("banked", banked_o, 20'h1);
		chk("data addr", data_addr_o, 20'h7ab);
		chk("cycles", cycles_o, 20'h1);
		put(16'h10cd, 1'b0, 1'b0, 4'h7);
		chk("dest acc", dest_acc_o, 20'h1);
		chk("dest file", dest_file_o, 20'h0);
		chk("data addr", data_addr_o, 20'h0cd);
	endtask

	task automatic t_bit();
		for (int b = 0; b < 8; b++) begin
			put(16'h6155 | 16'(b << 9), 1'b0, 1'b0, 4'h3);
			chk("cat bit", cat_o, 20'(CAT_BIT));
			chk("bit sel", bit_sel_o, 20'(b));
			chk("bit mask", bit_mask_o, 20'(1 << b));
			chk("bit file", data_addr_o, 20'h355);
		end
	endtask

	task automatic t_lit_ctrl();
		put(16'hb03c);
		chk("cat lit", cat_o, 20'(CAT_LIT));
		chk("literal", literal_o, 20'h3c);
		put(16'hc25a);
		chk("ptr sel", ptr_sel_o, 20'h2);
		for (int m = 0; m < 4; m++) begin
			put(16'h0200 | 16'(m));
			chk("cat ctrl", cat_o, 20'(CAT_CTRL));
			chk("tbl mode", tbl_mode_o, 20'(m));
		end
		put(16'h0301);
		chk("tbl write mode", tbl_mode_o, 20'(TBL_POSTINC));
		put(16'h0000);
		chk("nop", exec_nop_o, 20'h1);
		put(16'h0805, 1'b0, 1'b1);
		chk("ext op", ext_op_o, 20'h1);
		chk("ext idx", ext_idx_o, 20'h5);
		put(16'h0805);
		chk("ext off nop", exec_nop_o, 20'h1);
		put(16'h0101);
		chk("fast", fast_o, 20'h1);
		chk("ret cycles", cycles_o, 20'h2);
		flush();
		put(16'h0100);
		chk("no fast", fast_o, 20'h0);
		flush();
	endtask

	task automatic t_branch();
		put(16'h9155, 1'b1);
		chk("skip cycles", cycles_o, 20'h2);
		flush();
		put(16'h9155, 1'b0);
		chk("no skip cycles", cycles_o, 20'h1);
		put(16'hd7ff);
		chk("rel offset", prog_addr_o, 20'hfffff);
		chk("jump cycles", cycles_o, 20'h2);
		flush();
		put(16'hd805, 1'b0);
		chk("cond false", cycles_o, 20'h1);
		put(16'hd805, 1'b1);
		chk("cond true", cycles_o, 20'h2);
		flush();
	endtask

	task automatic t_dword();
		put(16'he012);
		chk("dw", dw_o, 20'h1);
		chk("dw cycles", cycles_o, 20'h2);
		put(16'hf345);
		chk("goto addr", prog_addr_o, 20'h12345);
		chk("second start", start_o, 20'h0);
		put(16'he180);
		chk("call fast", fast_o, 20'h1);
		put(16'hf000);
		put(16'he220);
		put(16'hf0ab);
		chk("load ptr", ptr_sel_o, 20'h2);
		chk("load lit", literal_o, 20'hab);
		put(16'he312, 1'b1);
		chk("long taken", cycles_o, 20'h3);
		put(16'hf345);
		flush();
		put(16'he312, 1'b0);
		chk("long not taken", cycles_o, 20'h2);
		put(16'hf345);
		put(16'hf123);
		chk("lone nop", exec_nop_o, 20'h1);
		chk("lone cycles", cycles_o, 20'h1);
	endtask

	//------------------------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------------------------
	initial begin
		miscompares  = 0;
		total_checks = 0;
		rst_n_i      = 1'b0;
		instr_i      = 16'h0000;
		cond_true_i  = 1'b0;
		ext_en_i     = 1'b0;
		bank_sel_i   = 4'h0;
		repeat (8) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		t_phase();
		t_byte();
		t_bit();
		t_lit_ctrl();
		t_branch();
		t_dword();
		summarize();
	end
endmodule

`default_nettype wire
